// ==== hw/bgc_pkg.sv ====
// Constants shared by the battery gauge counter register bank
package bgc_pkg;
	// Decoded address space
	localparam logic [15:0] BGC_TOP_DECODED = 16'h011F;
	localparam logic [15:0] BGC_ALIAS_BASE = 16'h0120;
	localparam logic [7:0] BGC_ALIAS_LOW_MIN = 8'h20;
	localparam logic [7:0] BGC_RAM_BASE = 8'hE0;
	localparam logic [15:0] BGC_REG_BASE = 16'h0100;
	// Register offsets
	localparam logic [15:0] BGC_OFS_RESERVED = 16'h0100;
	localparam logic [15:0] BGC_OFS_PAGE_PROTECT = 16'h0101;
	localparam logic [15:0] BGC_OFS_TEMP_LOW = 16'h0102;
	localparam logic [15:0] BGC_OFS_TEMP_HIGH = 16'h0103;
	localparam logic [15:0] BGC_OFS_CLEAR = 16'h0104;
	localparam logic [15:0] BGC_OFS_MODE = 16'h0105;
	localparam logic [15:0] BGC_OFS_CHG_TIME_LOW = 16'h0106;
	localparam logic [15:0] BGC_OFS_CHG_TIME_HIGH = 16'h0107;
	localparam logic [15:0] BGC_OFS_DIS_TIME_LOW = 16'h0108;
	localparam logic [15:0] BGC_OFS_DIS_TIME_HIGH = 16'h0109;
	localparam logic [15:0] BGC_OFS_DRAIN_LOW = 16'h010A;
	localparam logic [15:0] BGC_OFS_DRAIN_HIGH = 16'h010B;
	localparam logic [15:0] BGC_OFS_CHG_CNT_LOW = 16'h010C;
	localparam logic [15:0] BGC_OFS_CHG_CNT_HIGH = 16'h010D;
	localparam logic [15:0] BGC_OFS_DIS_CNT_LOW = 16'h010E;
	localparam logic [15:0] BGC_OFS_DIS_CNT_HIGH = 16'h010F;
	// Clear control bit positions
	localparam int BGC_CLR_DIS = 0;
	localparam int BGC_CLR_CHG = 1;
	localparam int BGC_CLR_DRAIN = 2;
	localparam int BGC_CLR_DIS_TIME = 3;
	localparam int BGC_CLR_CHG_TIME = 4;
	localparam int BGC_CLR_STAT = 5;
	localparam int BGC_CLR_POR = 6;
	// Mode register bit positions
	localparam int BGC_SLEEP_WAKE_MODE_LSB = 1;
	localparam int BGC_MODE_SLOW_DIS = 4;
	localparam int BGC_MODE_SLOW_CHG = 5;
	localparam int BGC_MODE_SLEEP_EN = 6;
	// Reset values
	localparam logic [6:0] BGC_PROTECT_RESET = 7'h7F;
	localparam logic [2:0] BGC_WOE_RESET = 3'h7;
	localparam logic [15:0] BGC_COUNT_RESET = 16'h0000;
	// Timebase: one fast tick per 0.8789 s, 4096 per hour
	localparam int BGC_CLK_KHZ = 100_000;
	localparam int BGC_TICK_US = 878_900;
	localparam int BGC_TICK_CYCLES = BGC_TICK_US * (BGC_CLK_KHZ / 1000);
	localparam int BGC_WAKE_MS = 4000;
	localparam int BGC_WAKE_CYCLES = BGC_WAKE_MS * BGC_CLK_KHZ;
	// Slow rate 16 per hour: one step per 256 fast ticks
	localparam int BGC_SLOW_DIV_BITS = 8;
	// Fast ticks per hour, as a low-bit mask of the tick counter
	localparam logic [15:0] BGC_HOUR_MASK = 16'h0FFF;
	// Die temperature band edges, 0.25 K per count: 0,10,..,60 C
	localparam logic [15:0] BGC_T0C = 16'h0445;
	localparam logic [15:0] BGC_T10C = 16'h046D;
	localparam logic [15:0] BGC_T20C = 16'h0495;
	localparam logic [15:0] BGC_T30C = 16'h04BD;
	localparam logic [15:0] BGC_T40C = 16'h04E5;
	localparam logic [15:0] BGC_T50C = 16'h050D;
	localparam logic [15:0] BGC_T60C = 16'h0535;
endpackage : bgc_pkg

// ==== hw/bgc_mem.sv ====
// Flash and RAM byte store with registered read data
`timescale 1ns/1ps
`default_nettype none
module bgc_mem #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Write side
	input wire logic wr_en,
	input wire logic and_mode,
	input wire logic [$clog2(DEPTH)-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	// Read side
	input wire logic rd_en,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] store [DEPTH];

	// Flash programming can only clear bits
	always_ff @(posedge clock) begin
		if (wr_en) begin
			if (and_mode) begin
				store[addr] <= store[addr] & wdata;
			end else begin
				store[addr] <= wdata;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rdata <= '0;
		end else if (rd_en) begin
			rdata <= store[addr];
		end
	end
endmodule : bgc_mem
`default_nettype wire

// ==== hw/bgc_regs.sv ====
// Battery gauge counter register bank with address decode and memory
//
// Functional notes
// - Nothing is decoded above 0x011F within the base space.
// - Bytes 0x20-0xFF repeat every 256 bytes starting at 0x0120.
// - Host writes 1 to a clear bit; device zeroes that counter pair.
// - Clear bit drops back to 0 by itself once zeroing is done.
// - Bits 0..4 clear discharge, charge, self-drain, discharge-time, charge-time.
// - Zeroing discharge time clears slow-discharge flag and restores fast rate.
// - Zeroing charge time clears slow-charge flag and restores fast rate.
// - Discharge count steps per 3.05 uVh while negative input is higher. Here it steps on every discharge_step pulse; the sense inputs are not checked.
// - Charge count steps per 3.05 uVh while positive input is higher. Here it steps on every charge_step pulse; the sense inputs are not checked.
// - Charge, discharge, self-drain counts wrap past FFFF without a flag.
// - Self-drain counts by time and temperature, 1/8 h to 16/h.
// - Self-drain keeps counting in sleep; hourly 4 s maintenance wake.
// - Discharge time advances 4096 per hour while discharging.
// - Discharge time rollover sets slow-discharge flag; then 16 per hour.
// - Second discharge time rollover clears the slow-discharge flag.
// - Charge time same scheme: 4096/h, rollover flag, 16/h, flag toggles.
// - Slow-charge flag is mode bit 5, slow-discharge flag bit 4.
`timescale 1ns/1ps
`default_nettype none
module bgc_regs
	import bgc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = BGC_TICK_CYCLES,
	parameter int unsigned WAKE_CYCLES = BGC_WAKE_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Byte access from the memory command engine
	input wire logic [15:0] acc_addr,
	input wire logic acc_wr,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_rd,
	output logic [7:0] acc_rdata,
	output logic acc_rvalid,
	// Converter front end, asynchronous
	input wire logic charge_step,
	input wire logic discharge_step,
	input wire logic sense_positive_above,
	input wire logic sense_negative_above,
	// Temperature sensor and sleep control, same clock
	input wire logic [15:0] die_temperature,
	input wire logic sleep_active,
	// Mode outputs
	output logic sleep_enable,
	output logic [2:0] wake_threshold_sel,
	output logic maintenance_wake,
	// Open-drain status pin
	output logic stat_out,
	output logic stat_oe
);
	typedef enum logic [2:0] {
		BGC_SEL_NONE = 3'b001,
		BGC_SEL_MEM = 3'b010,
		BGC_SEL_REG = 3'b100
	} bgc_sel_t;

	// Counter pair step with zeroing taking priority
	function automatic logic [15:0] bump(input logic [15:0] v,
		input logic zero, input logic inc);
		if (zero) begin
			return BGC_COUNT_RESET;
		end else if (inc) begin
			return v + 16'h0001;
		end
		return v;
	endfunction : bump

	// Slow flag toggles on each rollover past FFFF
	function automatic logic next_slow(input logic flag, input logic zero,
		input logic adv, input logic [15:0] v);
		if (zero) begin
			return 1'b0;
		end else if (adv && v == 16'hFFFF) begin
			return ~flag;
		end
		return flag;
	endfunction : next_slow

	// Self-drain divider exponent from temperature band
	function automatic logic [2:0] drain_shift(input logic [15:0] t);
		if (t >= BGC_T60C) begin
			return 3'h0;
		end else if (t >= BGC_T50C) begin
			return 3'h1;
		end else if (t >= BGC_T40C) begin
			return 3'h2;
		end else if (t >= BGC_T30C) begin
			return 3'h3;
		end else if (t >= BGC_T20C) begin
			return 3'h4;
		end else if (t >= BGC_T10C) begin
			return 3'h5;
		end else if (t >= BGC_T0C) begin
			return 3'h6;
		end
		return 3'h7;
	endfunction : drain_shift

	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [1:0] step_prev_q;
	logic chg_pulse;
	logic dis_pulse;
	logic charging;
	logic discharging;
	logic [31:0] tick_div_q;
	logic fast_tick;
	logic [15:0] tick_cnt_q;
	logic slow_step;
	logic [15:0] drain_mask;
	logic drain_adv;
	logic hour_mark;
	logic [31:0] wake_cnt_q;
	logic [15:0] dis_cnt_q;
	logic [15:0] chg_cnt_q;
	logic [15:0] drain_cnt_q;
	logic [15:0] dis_time_q;
	logic [15:0] chg_time_q;
	logic dis_time_adv;
	logic chg_time_adv;
	logic slow_dis_q;
	logic slow_chg_q;
	logic [4:0] clr_q;
	logic stat_q;
	logic por_q;
	logic sleep_en_q;
	logic [2:0] woe_q;
	logic [6:0] protect_q;
	logic [15:0] eff_addr;
	logic hit_mem;
	logic hit_reg;
	logic [7:0] reg_val;
	logic reg_wr;
	logic mem_wr;
	logic mem_rd;
	logic [7:0] mem_rdata;
	logic [7:0] reg_rdata_q;
	bgc_sel_t sel_q;
	logic rd1_q;
	logic [7:0] rdata_q;
	logic rvalid_q;

	// Front end pulses come from the converter domain
	always_ff @(posedge clock) begin
		if (reset) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			step_prev_q <= 2'h0;
		end else begin
			sync1_q <= {sense_negative_above, sense_positive_above,
				discharge_step, charge_step};
			sync2_q <= sync1_q;
			step_prev_q <= sync2_q[1:0];
		end
	end

	// Step inputs must stay high at least one clock to be seen
	assign chg_pulse = sync2_q[0] & ~step_prev_q[0];
	assign dis_pulse = sync2_q[1] & ~step_prev_q[1];
	assign charging = sync2_q[2] & ~sync2_q[3];
	assign discharging = sync2_q[3] & ~sync2_q[2];

	// Internal timebase, one fast tick per 0.8789 s
	always_ff @(posedge clock) begin
		if (reset) begin
			tick_div_q <= 32'h0;
		end else if (fast_tick) begin
			tick_div_q <= 32'h0;
		end else begin
			tick_div_q <= tick_div_q + 32'h1;
		end
	end

	assign fast_tick = (tick_div_q == TICK_CYCLES - 32'h1);

	always_ff @(posedge clock) begin
		if (reset) begin
			tick_cnt_q <= 16'h0;
		end else if (fast_tick) begin
			tick_cnt_q <= tick_cnt_q + 16'h1;
		end
	end

	// One slow step every 256 fast ticks gives 16 per hour
	assign slow_step = (tick_cnt_q[BGC_SLOW_DIV_BITS-1:0] == '0);
	assign drain_mask = (16'h0100 << drain_shift(die_temperature)) - 16'h0001;
	assign drain_adv = fast_tick && ((tick_cnt_q & drain_mask) == 16'h0);
	assign hour_mark = fast_tick && ((tick_cnt_q & BGC_HOUR_MASK) == 16'h0);

	// Timebase and self-drain run on regardless of sleep
	always_ff @(posedge clock) begin
		if (reset) begin
			wake_cnt_q <= 32'h0;
		end else if (hour_mark && sleep_active) begin
			wake_cnt_q <= WAKE_CYCLES;
		end else if (wake_cnt_q != 32'h0) begin
			wake_cnt_q <= wake_cnt_q - 32'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			maintenance_wake <= 1'b0;
		end else begin
			maintenance_wake <= (hour_mark && sleep_active) ||
				(wake_cnt_q > 32'h1);
		end
	end

	// Coulomb and self-drain counters wrap silently
	always_ff @(posedge clock) begin
		if (reset) begin
			dis_cnt_q <= BGC_COUNT_RESET;
			chg_cnt_q <= BGC_COUNT_RESET;
			drain_cnt_q <= BGC_COUNT_RESET;
		end else begin
			dis_cnt_q <= bump(dis_cnt_q, clr_q[BGC_CLR_DIS],
				dis_pulse);
			chg_cnt_q <= bump(chg_cnt_q, clr_q[BGC_CLR_CHG],
				chg_pulse);
			drain_cnt_q <= bump(drain_cnt_q, clr_q[BGC_CLR_DRAIN],
				drain_adv);
		end
	end

	// Time counters drop to 16 per hour while their slow flag is set
	assign dis_time_adv = discharging && fast_tick &&
		(!slow_dis_q || slow_step);
	assign chg_time_adv = charging && fast_tick &&
		(!slow_chg_q || slow_step);

	always_ff @(posedge clock) begin
		if (reset) begin
			dis_time_q <= BGC_COUNT_RESET;
			slow_dis_q <= 1'b0;
		end else begin
			dis_time_q <= bump(dis_time_q, clr_q[BGC_CLR_DIS_TIME],
				dis_time_adv);
			slow_dis_q <= next_slow(slow_dis_q, clr_q[BGC_CLR_DIS_TIME],
				dis_time_adv, dis_time_q);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			chg_time_q <= BGC_COUNT_RESET;
			slow_chg_q <= 1'b0;
		end else begin
			chg_time_q <= bump(chg_time_q, clr_q[BGC_CLR_CHG_TIME],
				chg_time_adv);
			slow_chg_q <= next_slow(slow_chg_q, clr_q[BGC_CLR_CHG_TIME],
				chg_time_adv, chg_time_q);
		end
	end

	// Address decode, aliases fold onto the low page
	always_comb begin
		eff_addr = acc_addr;
		hit_mem = 1'b0;
		hit_reg = 1'b0;
		if (acc_addr < BGC_REG_BASE) begin
			hit_mem = 1'b1;
		end else if (acc_addr <= BGC_TOP_DECODED) begin
			hit_reg = 1'b1;
		end else if (acc_addr[7:0] >= BGC_ALIAS_LOW_MIN) begin
			eff_addr = {8'h00, acc_addr[7:0]};
			hit_mem = 1'b1;
		end
	end

	// Alias writes really land in memory, so a stray host write corrupts it
	assign mem_wr = acc_wr && hit_mem;
	assign mem_rd = acc_rd && hit_mem;
	assign reg_wr = acc_wr && hit_reg;

	// Clear bits live one cycle: set by host, gone once counters are zero
	always_ff @(posedge clock) begin
		if (reset) begin
			clr_q <= 5'h00;
		end else if (reg_wr && acc_addr == BGC_OFS_CLEAR) begin
			clr_q <= acc_wdata[BGC_CLR_CHG_TIME:BGC_CLR_DIS];
		end else begin
			clr_q <= 5'h00;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			stat_q <= 1'b1;
			por_q <= 1'b1;
		end else if (reg_wr && acc_addr == BGC_OFS_CLEAR) begin
			stat_q <= acc_wdata[BGC_CLR_STAT];
			por_q <= acc_wdata[BGC_CLR_POR];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sleep_en_q <= 1'b1;
			woe_q <= BGC_WOE_RESET;
		end else if (reg_wr && acc_addr == BGC_OFS_MODE) begin
			sleep_en_q <= acc_wdata[BGC_MODE_SLEEP_EN];
			woe_q <= acc_wdata[BGC_SLEEP_WAKE_MODE_LSB+:3];
		end
	end

	// Protection bits can only be cleared, like flash
	always_ff @(posedge clock) begin
		if (reset) begin
			protect_q <= BGC_PROTECT_RESET;
		end else if (reg_wr && acc_addr == BGC_OFS_PAGE_PROTECT) begin
			protect_q <= protect_q & acc_wdata[6:0];
		end
	end

	// Register read value; reserved and empty locations read zero
	always_comb begin
		reg_val = 8'h00;
		if (acc_addr == BGC_OFS_RESERVED) begin
			reg_val = 8'h00;
		end else if (acc_addr == BGC_OFS_PAGE_PROTECT) begin
			reg_val = {1'b0, protect_q};
		end else if (acc_addr == BGC_OFS_TEMP_LOW) begin
			reg_val = die_temperature[7:0];
		end else if (acc_addr == BGC_OFS_TEMP_HIGH) begin
			reg_val = die_temperature[15:8];
		end else if (acc_addr == BGC_OFS_CLEAR) begin
			reg_val = {1'b0, por_q, stat_q, clr_q};
		end else if (acc_addr == BGC_OFS_MODE) begin
			reg_val = {1'b0, sleep_en_q, slow_chg_q, slow_dis_q,
				woe_q, 1'b0};
		end else if (acc_addr == BGC_OFS_CHG_TIME_LOW) begin
			reg_val = chg_time_q[7:0];
		end else if (acc_addr == BGC_OFS_CHG_TIME_HIGH) begin
			reg_val = chg_time_q[15:8];
		end else if (acc_addr == BGC_OFS_DIS_TIME_LOW) begin
			reg_val = dis_time_q[7:0];
		end else if (acc_addr == BGC_OFS_DIS_TIME_HIGH) begin
			reg_val = dis_time_q[15:8];
		end else if (acc_addr == BGC_OFS_DRAIN_LOW) begin
			reg_val = drain_cnt_q[7:0];
		end else if (acc_addr == BGC_OFS_DRAIN_HIGH) begin
			reg_val = drain_cnt_q[15:8];
		end else if (acc_addr == BGC_OFS_CHG_CNT_LOW) begin
			reg_val = chg_cnt_q[7:0];
		end else if (acc_addr == BGC_OFS_CHG_CNT_HIGH) begin
			reg_val = chg_cnt_q[15:8];
		end else if (acc_addr == BGC_OFS_DIS_CNT_LOW) begin
			reg_val = dis_cnt_q[7:0];
		end else if (acc_addr == BGC_OFS_DIS_CNT_HIGH) begin
			reg_val = dis_cnt_q[15:8];
		end
	end

	bgc_mem #(
		.DEPTH(256),
		.WIDTH(8)
	) u_mem (
		.clock(clock),
		.reset(reset),
		.wr_en(mem_wr),
		.and_mode(eff_addr[7:0] < BGC_RAM_BASE),
		.addr(eff_addr[7:0]),
		.wdata(acc_wdata),
		.rd_en(mem_rd),
		.rdata(mem_rdata)
	);

	// Two-stage read so the output byte always comes from a flop
	always_ff @(posedge clock) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
			sel_q <= BGC_SEL_NONE;
			rd1_q <= 1'b0;
		end else begin
			rd1_q <= acc_rd;
			reg_rdata_q <= reg_val;
			if (acc_rd && hit_mem) begin
				sel_q <= BGC_SEL_MEM;
			end else if (acc_rd && hit_reg) begin
				sel_q <= BGC_SEL_REG;
			end else begin
				sel_q <= BGC_SEL_NONE;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd1_q;
			case (sel_q)
				BGC_SEL_MEM: begin
					rdata_q <= mem_rdata;
				end
				BGC_SEL_REG: begin
					rdata_q <= reg_rdata_q;
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end
	end

	assign acc_rdata = rdata_q;
	assign acc_rvalid = rvalid_q;
	assign sleep_enable = sleep_en_q;
	assign wake_threshold_sel = woe_q;
	// Pin pulls low while the status bit is 0
	assign stat_out = 1'b0;
	assign stat_oe = ~stat_q;
endmodule : bgc_regs
`default_nettype wire

// ==== sim/bgc_regs_properties.sv ====
// Port checker for the gauge register bank
`timescale 1ns/1ps
`default_nettype none
module bgc_regs_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Access port
	input wire logic [15:0] acc_addr,
	input wire logic acc_wr,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_rd,
	input wire logic [7:0] acc_rdata,
	input wire logic acc_rvalid,
	// Sleep
	input wire logic sleep_active,
	input wire logic maintenance_wake
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire logic clr_wr = acc_wr && acc_addr == 16'h0104;
	AST_READ_LATENCY: assert property (acc_rd |-> ##2 acc_rvalid)
		else $error("read answer late");
	AST_RESERVED_ZERO: assert property (acc_rd && acc_addr == 16'h0100 |-> ##2 acc_rdata == 8'h00)
		else $error("reserved byte not zero");
	AST_ABOVE_TOP: assert property (acc_rd && acc_addr inside {[16'h0110:16'h011F]} |-> ##2 acc_rdata == 8'h00)
		else $error("undecoded byte not zero");
	AST_LOW_HOLE: assert property (acc_rd && acc_addr >= 16'h0200 && acc_addr[7:0] < 8'h20 |-> ##2 acc_rdata == 8'h00)
		else $error("non aliased byte not zero");
	AST_CLEAR_SELF: assert property (clr_wr && acc_wdata[4:0] != 5'h00 ##1 !clr_wr ##1 acc_rd && acc_addr == 16'h0104 |-> ##2 acc_rdata[4:0] == 5'h00)
		else $error("clear bit stuck");
	AST_CHG_ZERO: assert property (clr_wr && acc_wdata[1] ##2 acc_rd && acc_addr == 16'h010C |-> ##2 acc_rdata == 8'h00)
		else $error("charge count not zeroed");
	AST_FLAG_DIS: assert property (clr_wr && acc_wdata[3] ##2 acc_rd && acc_addr == 16'h0105 |-> ##2 !acc_rdata[4])
		else $error("slow discharge flag kept");
	AST_FLAG_CHG: assert property (clr_wr && acc_wdata[4] ##2 acc_rd && acc_addr == 16'h0105 |-> ##2 !acc_rdata[5])
		else $error("slow charge flag kept");
	AST_WAKE_SLEEP: assert property ($rose(maintenance_wake) |-> $past(sleep_active))
		else $error("maintenance wake while awake");
	// Main scenarios
	cover property (clr_wr ##2 acc_rd);
	cover property ($rose(maintenance_wake));
	cover property (acc_rd && acc_addr == 16'h01E5);
endmodule : bgc_regs_checker
bind bgc_regs bgc_regs_checker i_bgc_regs_checker (.clock(clock), .reset(reset),
	.acc_addr(acc_addr), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
	.acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
	.sleep_active(sleep_active), .maintenance_wake(maintenance_wake));
`default_nettype wire

// ==== sim/bgc_host.sv ====
// Host model driving the byte access port
`timescale 1ns/1ps
`default_nettype none
module bgc_host (
	// Clock
	input wire logic clock,
	// Access port
	output logic [15:0] acc_addr,
	output logic acc_wr,
	output logic [7:0] acc_wdata,
	output logic acc_rd,
	input wire logic [7:0] acc_rdata,
	input wire logic acc_rvalid
);
	initial begin
		acc_addr = 16'h0000;
		acc_wr = 1'b0;
		acc_wdata = 8'h00;
		acc_rd = 1'b0;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		// Aliased writes would overwrite memory
		if (a >= 16'h0120) return;
		acc_wr <= 1'b1;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge clock);
		acc_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] v,
		output logic ok);
		acc_rd <= 1'b1;
		acc_addr <= a;
		@(posedge clock);
		acc_rd <= 1'b0;
		acc_addr <= ~a;
		repeat (2) @(negedge clock);
		ok = acc_rvalid;
		v = acc_rdata;
		@(posedge clock);
	endtask : rd
endmodule : bgc_host
`default_nettype wire

// ==== sim/bgc_regs_tb_top.sv ====
// Testbench for the gauge register bank
`timescale 1ns/1ps
`default_nettype none
module bgc_regs_tb_top;
	logic clock, reset, acc_wr, acc_rd, acc_rvalid;
	logic [15:0] acc_addr, die_temperature;
	logic [7:0] acc_wdata, acc_rdata;
	logic charge_step, discharge_step, sense_positive_above;
	logic sense_negative_above, sleep_active, sleep_enable;
	logic maintenance_wake, stat_out, stat_oe;
	logic [2:0] wake_threshold_sel;
	int miscompares = 0;
	int checked = 0;
	// Short tick keeps the rollover inside the run
	bgc_regs #(.TICK_CYCLES(1), .WAKE_CYCLES(10)) i_bgc_regs (
		.clock(clock), .reset(reset), .acc_addr(acc_addr), .acc_wr(acc_wr),
		.acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata(acc_rdata),
		.acc_rvalid(acc_rvalid), .charge_step(charge_step),
		.discharge_step(discharge_step),
		.sense_positive_above(sense_positive_above),
		.sense_negative_above(sense_negative_above),
		.die_temperature(die_temperature), .sleep_active(sleep_active),
		.sleep_enable(sleep_enable), .wake_threshold_sel(wake_threshold_sel),
		.maintenance_wake(maintenance_wake), .stat_out(stat_out),
		.stat_oe(stat_oe));
	bgc_host i_bgc_host (.clock(clock), .acc_addr(acc_addr), .acc_wr(acc_wr),
		.acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata(acc_rdata),
		.acc_rvalid(acc_rvalid));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic complete_run();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task automatic check(input string n, input logic [7:0] seen, e);
		checked++;
		if (seen !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, seen);
		end
	endtask : check
	task automatic rdv(input logic [15:0] a, output logic [7:0] v);
		logic ok;
		i_bgc_host.rd(a, v, ok);
		check("read valid", {7'h00, ok}, 8'h01);
	endtask : rdv
	task automatic rdc(input string n, input logic [15:0] a, logic [7:0] e);
		logic [7:0] v;
		rdv(a, v);
		check(n, v, e);
	endtask : rdc
	task automatic rdr(input string n, input logic [15:0] a,
		input logic [7:0] lo, hi);
		logic [7:0] v;
		rdv(a, v);
		check(n, {7'h00, v >= lo && v <= hi}, 8'h01);
	endtask : rdr
	// Read lands two cycles after the clear write
	task automatic clear_rd(input logic [7:0] bits, input logic [15:0] a,
		output logic [7:0] v);
		i_bgc_host.wr(16'h0104, bits | 8'h20);
		@(posedge clock);
		rdv(a, v);
	endtask : clear_rd
	task automatic steps(input int n, input logic dis);
		repeat (n) begin
			charge_step <= !dis;
			discharge_step <= dis;
			repeat (3) @(posedge clock);
			charge_step <= 1'b0;
			discharge_step <= 1'b0;
			repeat (3) @(posedge clock);
		end
		repeat (4) @(posedge clock);
	endtask : steps
	task automatic t_reset();
		rdc("clear register", 16'h0104, 8'h60);
		rdc("mode register", 16'h0105, 8'h4E);
		rdc("temperature low", 16'h0102, 8'hA8);
		rdc("temperature high", 16'h0103, 8'h04);
		check("sleep enable", {7'h00, sleep_enable}, 8'h01);
		check("wake select", {5'h00, wake_threshold_sel}, 8'h07);
		check("status pin", {6'h00, stat_out, stat_oe}, 8'h00);
		i_bgc_host.wr(16'h0104, 8'h00);
		@(posedge clock);
		check("status pin on", {6'h00, stat_out, stat_oe}, 8'h01);
	endtask : t_reset
	task automatic t_counts();
		logic [7:0] v;
		steps(5, 1'b0);
		steps(3, 1'b1);
		rdc("charge low", 16'h010C, 8'h05);
		rdc("charge high", 16'h010D, 8'h00);
		rdc("discharge low", 16'h010E, 8'h03);
		clear_rd(8'h02, 16'h010C, v);
		check("charge zeroed", v, 8'h00);
		rdc("discharge kept", 16'h010E, 8'h03);
		clear_rd(8'h01, 16'h010E, v);
		check("discharge zeroed", v, 8'h00);
		clear_rd(8'h04, 16'h010A, v);
		check("self drain zeroed", v, 8'h00);
		clear_rd(8'h1F, 16'h0104, v);
		check("clear bits", {3'h0, v[4:0]}, 8'h00);
	endtask : t_counts
	task automatic t_map();
		i_bgc_host.wr(16'h00E5, 8'h5A);
		rdc("ram byte", 16'h00E5, 8'h5A);
		rdc("alias byte", 16'h01E5, 8'h5A);
		rdc("reserved", 16'h0100, 8'h00);
		rdc("above top", 16'h0110, 8'h00);
		rdc("top", 16'h011F, 8'h00);
		rdc("low hole", 16'h0205, 8'h00);
	endtask : t_map
	task automatic t_time();
		logic [7:0] v;
		sense_positive_above <= 1'b1;
		repeat (100) @(posedge clock);
		sense_positive_above <= 1'b0;
		repeat (4) @(posedge clock);
		rdr("charge time", 16'h0106, 8'd94, 8'd101);
		clear_rd(8'h10, 16'h0105, v);
		check("slow charge flag", {7'h00, v[5]}, 8'h00);
		rdc("charge time zeroed", 16'h0106, 8'h00);
		sense_negative_above <= 1'b1;
		repeat (1000) @(posedge clock);
		rdc("discharge time fast", 16'h0109, 8'h03);
		repeat (65000) @(posedge clock);
		rdv(16'h0105, v);
		check("slow discharge flag", {7'h00, v[4]}, 8'h01);
		rdc("slow time high", 16'h0109, 8'h00);
		rdr("slow time low", 16'h0108, 8'd0, 8'd3);
		clear_rd(8'h08, 16'h0105, v);
		check("flag after clear", {7'h00, v[4]}, 8'h00);
		repeat (60) @(posedge clock);
		rdr("fast rate back", 16'h0108, 8'd55, 8'd72);
		sense_negative_above <= 1'b0;
	endtask : t_time
	task automatic t_sleep();
		logic seen;
		seen = 1'b0;
		sleep_active <= 1'b1;
		repeat (4200) begin
			@(posedge clock);
			if (maintenance_wake === 1'b1) seen = 1'b1;
		end
		sleep_active <= 1'b0;
		check("maintenance wake", {7'h00, seen}, 8'h01);
	endtask : t_sleep
	initial begin
		repeat (90000) @(posedge clock);
		miscompares++;
		complete_run();
	end
	initial begin
		reset = 1'b1;
		charge_step = 1'b0;
		discharge_step = 1'b0;
		sense_positive_above = 1'b0;
		sense_negative_above = 1'b0;
		die_temperature = 16'h04A8;
		sleep_active = 1'b0;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_reset();
		t_counts();
		t_map();
		t_time();
		t_sleep();
		complete_run();
	end
endmodule : bgc_regs_tb_top
`default_nettype wire
